// >>> tpc_pin_control.sv
`include "tpc_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module tpc_pin_control
    import tpc_pkg::*;
#(
    parameter int RESET_HOLD_CYC = `TPC_RESET_HOLD_CYC
)
(
    input  wire logic          i_mclk,
    input  wire logic          i_srst,
    input  wire logic          i_reset_n_pin,
    input  wire logic          i_wake_pin,
    input  wire logic [5:0]    i_pin_in,
    output tpc_pins_s          o_pins,
    input  wire logic [2:0]    i_rf_ctrl,
    input  wire logic          i_slow_tick_xtal,
    input  wire logic          i_slow_tick_int,
    output logic               o_int_pin,
    output logic               o_wake_event,
    output logic               o_asleep,
    output logic               o_core_reset,
    input  wire logic [31:0]   s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [31:0]   s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready
);

    // ****************************************
    // Register map decode
    // ****************************************
    function automatic logic [3:0] reg_sel(input logic [31:0] addr);
        logic [11:0] idx;
        idx = addr[13:2];
        reg_sel = 4'hf;
        if (addr[1:0] == 2'b00 && addr[31:14] == 18'h0)
        begin
            unique case (idx)
                `TPC_IDX_PIN_DATA:      reg_sel = 4'h0;
                `TPC_IDX_PIN_DIRECTION: reg_sel = 4'h1;
                `TPC_IDX_SLEEP_CFG0:    reg_sel = 4'h2;
                `TPC_IDX_INT_STATUS:    reg_sel = 4'h3;
                `TPC_IDX_INT_MASK:      reg_sel = 4'h4;
                `TPC_IDX_INT_ENABLE:    reg_sel = 4'h5;
                `TPC_IDX_CONTROL:       reg_sel = 4'h6;
                `TPC_IDX_SLEEP_PERIOD:  reg_sel = 4'h7;
                `TPC_IDX_RF_OVERRIDE:   reg_sel = 4'h8;
                default:                reg_sel = 4'hf;
            endcase
        end
    endfunction

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic       rst_meta;
    logic       rst_sync;
    logic       wake_meta;
    logic       wake_sync;
    logic       wake_prev;
    logic [5:0] pin_meta;
    logic [5:0] pin_sync;
    logic [5:0] pin_prev;
    logic       xt_meta;
    logic       xt_sync;
    logic       xt_prev;
    logic       io_meta;
    logic       io_sync;
    logic       io_prev;

    // Two-stage capture of external levels
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            rst_meta  <= 1'b0;
            rst_sync  <= 1'b0;
            wake_meta <= 1'b0;
            wake_sync <= 1'b0;
            wake_prev <= 1'b0;
            pin_meta  <= 6'h00;
            pin_sync  <= 6'h00;
            pin_prev  <= 6'h00;
            xt_meta   <= 1'b0;
            xt_sync   <= 1'b0;
            xt_prev   <= 1'b0;
            io_meta   <= 1'b0;
            io_sync   <= 1'b0;
            io_prev   <= 1'b0;
        end
        else
        begin
            rst_meta  <= i_reset_n_pin;
            rst_sync  <= rst_meta;
            wake_meta <= i_wake_pin;
            wake_sync <= wake_meta;
            wake_prev <= wake_sync;
            pin_meta  <= i_pin_in;
            pin_sync  <= pin_meta;
            pin_prev  <= pin_sync;
            xt_meta   <= i_slow_tick_xtal;
            xt_sync   <= xt_meta;
            xt_prev   <= xt_sync;
            io_meta   <= i_slow_tick_int;
            io_sync   <= io_meta;
            io_prev   <= io_sync;
        end
    end

    // ****************************************
    // Reset release delay
    // ****************************************
    logic [31:0] hold_cnt;
    logic        core_rst;

    // Count main clock cycles after the pin rises
    always_ff @(posedge i_mclk)
    begin
        if (i_srst || !rst_sync)
        begin
            hold_cnt <= 32'h0;
            core_rst <= 1'b1;
        end
        else if (core_rst)
        begin
            hold_cnt <= hold_cnt + 32'h1;
            if (hold_cnt >= 32'(RESET_HOLD_CYC - 1))
                core_rst <= 1'b0;
        end
    end
    assign o_core_reset = core_rst;

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0]  pin_data;
    logic [7:0]  pin_direction;
    logic [7:0]  sleep_config_zero;
    logic [2:0]  int_status;
    logic [2:0]  int_mask;
    logic [2:0]  int_enable;
    logic [7:0]  control;
    logic [15:0] sleep_period;
    logic [2:0]  rf_override;
    logic [2:0]  events;

    logic        aw_held;
    logic        w_held;
    logic [31:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    tpc_wr_e     wr_state;
    logic        wr_fire;
    logic [3:0]  wr_sel;

    // Either channel may arrive first
    always_ff @(posedge i_mclk)
    begin
        if (core_rst)
        begin
            aw_held  <= 1'b0;
            w_held   <= 1'b0;
            aw_addr  <= 32'h0;
            w_data   <= 32'h0;
            w_strb   <= 4'h0;
            wr_state <= TPC_WR_IDLE;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            unique case (wr_state)
                TPC_WR_IDLE:
                    if (wr_fire)
                    begin
                        aw_held  <= 1'b0;
                        w_held   <= 1'b0;
                        wr_state <= TPC_WR_RESP;
                    end
                TPC_WR_RESP:
                    if (s_axi_bready)
                        wr_state <= TPC_WR_IDLE;
            endcase
        end
    end
    assign s_axi_awready = !aw_held && wr_state == TPC_WR_IDLE;
    assign s_axi_wready  = !w_held && wr_state == TPC_WR_IDLE;
    assign s_axi_bvalid  = wr_state == TPC_WR_RESP;
    assign wr_fire       = aw_held && w_held && wr_state == TPC_WR_IDLE;
    assign wr_sel        = reg_sel(aw_addr);

    logic [1:0] bresp;
    // Write response code latched with the write
    always_ff @(posedge i_mclk)
    begin
        if (core_rst)
            bresp <= 2'b00;
        else if (wr_fire)
            bresp <= (wr_sel == 4'hf) ? 2'b10 : 2'b00;
    end
    assign s_axi_bresp = bresp;

    // Software writable registers
    always_ff @(posedge i_mclk)
    begin
        if (core_rst)
        begin
            pin_data          <= `TPC_RST_PIN_DATA;
            pin_direction     <= `TPC_RST_PIN_DIRECTION;
            sleep_config_zero <= `TPC_RST_SLEEP_CFG0;
            int_mask          <= 3'h7;
            int_enable        <= 3'h0;
            control           <= 8'h00;
            sleep_period      <= 16'h0010;
            rf_override       <= 3'h0;
        end
        else if (wr_fire && w_strb[0])
        begin
            unique case (wr_sel)
                4'h0: pin_data          <= {2'b00, w_data[5:0]};
                4'h1: pin_direction     <= {2'b00, w_data[5:0]};
                4'h2: sleep_config_zero <= w_data[7:0];
                4'h4: int_mask          <= w_data[2:0];
                4'h5: int_enable        <= w_data[2:0];
                4'h6: control           <= w_data[7:0];
                4'h7: sleep_period      <= {w_strb[1] ? w_data[15:8] : sleep_period[15:8], w_data[7:0]};
                4'h8: rf_override       <= w_data[2:0];
                default: ;
            endcase
        end
    end

    // Sticky status: set wins over write-one clear
    always_ff @(posedge i_mclk)
    begin
        if (core_rst)
            int_status <= 3'h0;
        else if (wr_fire && wr_sel == 4'h3 && w_strb[0])
            int_status <= (int_status & ~w_data[2:0]) | events;
        else
            int_status <= int_status | events;
    end

    // Gate with enable and clear mask onto level
    logic int_active;
    assign int_active = |(int_status & int_enable & ~int_mask);
    assign o_int_pin  = sleep_config_zero[`TPC_BIT_INT_EDGE] ? int_active : !int_active;

    // ****************************************
    // Read channel
    // ****************************************
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic [3:0]  rd_sel;
    assign rd_sel = reg_sel(s_axi_araddr);

    // One-cycle read answer
    always_ff @(posedge i_mclk)
    begin
        if (core_rst)
        begin
            rvalid <= 1'b0;
            rdata  <= 32'h0;
            rresp  <= 2'b00;
        end
        else if (rvalid)
        begin
            if (s_axi_rready)
                rvalid <= 1'b0;
        end
        else if (s_axi_arvalid)
        begin
            rvalid <= 1'b1;
            rresp  <= (rd_sel == 4'hf) ? 2'b10 : 2'b00;
            unique case (rd_sel)
                4'h0: rdata <= {26'h0, pin_sync};
                4'h1: rdata <= {24'h0, pin_direction};
                4'h2: rdata <= {24'h0, sleep_config_zero};
                4'h3: rdata <= {29'h0, int_status};
                4'h4: rdata <= {29'h0, int_mask};
                4'h5: rdata <= {29'h0, int_enable};
                4'h6: rdata <= {23'h0, o_asleep, control};
                4'h7: rdata <= {16'h0, sleep_period};
                4'h8: rdata <= {29'h0, rf_override};
                default: rdata <= 32'h0;
            endcase
        end
    end
    assign s_axi_arready = !rvalid;
    assign s_axi_rvalid  = rvalid;
    assign s_axi_rdata   = rdata;
    assign s_axi_rresp   = rresp;

    // ****************************************
    // General pins
    // ****************************************
    tpc_pins_s pins;
    // Per-pin direction, RF control on pins 0-2
    always_ff @(posedge i_mclk)
    begin
        if (core_rst)
            pins <= '0;
        else
        begin
            pins.oe  <= pin_direction[5:0] | {3'b000, rf_override};
            pins.out <= {pin_data[5:3],
                         (rf_override & i_rf_ctrl) | (~rf_override & pin_data[2:0])};
        end
    end
    assign o_pins = pins;

    // ****************************************
    // Sleep counters and wake
    // ****************************************
    tpc_sleep_e  sl_state;
    logic [15:0] sl_cnt;
    logic        slow_tick;
    logic        wake_rise;
    logic        sleep_done;

    // Sleep clock source select
    assign slow_tick = sleep_config_zero[`TPC_BIT_SLEEP_CLK_SEL]
                     ? (io_sync && !io_prev) : (xt_sync && !xt_prev);
    assign wake_rise = control[`TPC_BIT_WAKE_EN] && wake_sync && !wake_prev;
    assign o_wake_event = wake_rise;

    // Beacon mode: active then inactive; else one interval
    always_ff @(posedge i_mclk)
    begin
        if (core_rst)
        begin
            sl_state   <= TPC_SL_AWAKE;
            sl_cnt     <= 16'h0;
            sleep_done <= 1'b0;
        end
        else
        begin
            sleep_done <= 1'b0;
            unique case (sl_state)
                TPC_SL_AWAKE:
                    if (control[`TPC_BIT_SLEEP_GO] && !wake_rise)
                    begin
                        sl_state <= control[`TPC_BIT_BEACON_MODE] ? TPC_SL_ACTIVE : TPC_SL_INACTIVE;
                        sl_cnt   <= 16'h0;
                    end
                TPC_SL_ACTIVE, TPC_SL_INACTIVE:
                    if (wake_rise)
                        sl_state <= TPC_SL_AWAKE;
                    else if (slow_tick)
                    begin
                        sl_cnt <= sl_cnt + 16'h1;
                        if (sl_cnt + 16'h1 >= sleep_period)
                        begin
                            sl_cnt     <= 16'h0;
                            sl_state   <= (sl_state == TPC_SL_ACTIVE) ? TPC_SL_INACTIVE : TPC_SL_AWAKE;
                            sleep_done <= sl_state == TPC_SL_INACTIVE;
                        end
                    end
                default: sl_state <= TPC_SL_AWAKE;
            endcase
        end
    end
    assign o_asleep = sl_state == TPC_SL_INACTIVE;

    // Event sources for the status register
    assign events = {|(pin_sync ^ pin_prev), sleep_done, wake_rise};

endmodule
`default_nettype wire

// >>> tpc_defs.svh
// How it works
// - Low reset input holds all logic except the pin synchronisers in reset
// - Stay in reset about 250 us after release
// - Interrupt edge select bit 1, reset falling
// - Interrupt pin only for enabled, unmasked sources
// - Wake input ignored until software enables it
// - Enabled wake input triggers wake from sleep
// - Six general pins, each input or output
// - Direction from pin direction register bit
// - Data register reads levels, writes outputs
// - RF state machine may drive pins 0-2
// - Sleep clock selects 32 kHz or 100 kHz source
// - Sleep counter times beacon or sleep interval
// - Main clock from 50 MHz oscillator
`ifndef TPC_DEFS_SVH
`define TPC_DEFS_SVH

// ****************************************
// Register word indices (byte address bits 13:2)
// ****************************************
`define TPC_IDX_PIN_DATA      12'h033
`define TPC_IDX_PIN_DIRECTION 12'h034
`define TPC_IDX_SLEEP_CFG0    12'h211
`define TPC_IDX_INT_STATUS    12'h300
`define TPC_IDX_INT_MASK      12'h301
`define TPC_IDX_INT_ENABLE    12'h302
`define TPC_IDX_CONTROL       12'h303
`define TPC_IDX_SLEEP_PERIOD  12'h304
`define TPC_IDX_RF_OVERRIDE   12'h305

// ****************************************
// Field positions and reset values
// ****************************************
`define TPC_BIT_INT_EDGE      1
`define TPC_BIT_SLEEP_CLK_SEL 0
`define TPC_BIT_WAKE_EN       0
`define TPC_BIT_SLEEP_GO      1
`define TPC_BIT_BEACON_MODE   2
`define TPC_RST_SLEEP_CFG0    8'h00
`define TPC_RST_PIN_DIRECTION 8'h00
`define TPC_RST_PIN_DATA      8'h00
`define TPC_NUM_EVENTS        3
`define TPC_EV_WAKE           0
`define TPC_EV_SLEEP_DONE     1
`define TPC_EV_PIN_CHANGE     2

// ****************************************
// Timing
// ****************************************
`define TPC_CLK_MHZ           50
`define TPC_RESET_HOLD_US     250
`define TPC_RESET_HOLD_CYC    (`TPC_RESET_HOLD_US * `TPC_CLK_MHZ)

`endif

// >>> tpc_pkg.sv
package tpc_pkg;
    // Write channel progress
    typedef enum logic [1:0]
    {
        TPC_WR_IDLE = 2'b00,
        TPC_WR_RESP = 2'b01
    } tpc_wr_e;

    // Sleep sequencer states
    typedef enum logic [1:0]
    {
        TPC_SL_AWAKE    = 2'b00,
        TPC_SL_ACTIVE   = 2'b01,
        TPC_SL_INACTIVE = 2'b10
    } tpc_sleep_e;

    // General pin bundle
    typedef struct packed
    {
        logic [5:0] out;
        logic [5:0] oe;
    } tpc_pins_s;
endpackage

// >>> tpc_pin_control_props.sv
`timescale 1ns/1ns
`default_nettype none
module tpc_pin_control_props
    import tpc_pkg::*;
#(
    parameter int RESET_HOLD_CYC = 20
)
(
    input wire logic        i_mclk,
    input wire logic        i_srst,
    input wire logic        i_reset_n_pin,
    input wire tpc_pins_s   o_pins,
    input wire logic        o_int_pin,
    input wire logic        o_wake_event,
    input wire logic        o_asleep,
    input wire logic        o_core_reset,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_srst);

    // ****
    // Helper state
    // ****
    logic [15:0] hold_cnt;
    logic        wake_en;
    logic        wr_go;

    // Both write channels taken at one edge
    assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

    // Length of the current internal reset
    always_ff @(posedge i_mclk)
        hold_cnt <= (i_srst || !o_core_reset) ? 16'h0000 : hold_cnt + 16'h0001;

    // Wake enable as last written to the control word
    always_ff @(posedge i_mclk)
        if (i_srst || o_core_reset)
            wake_en <= 1'b0;
        else if (wr_go && s_axi_wstrb[0] && s_axi_awaddr == 32'h0000_0c0c)
            wake_en <= s_axi_wdata[0];

    // ****
    // Properties
    // ****
    property p_pin_reset;
        !i_reset_n_pin |-> ##[1:3] o_core_reset;
    endproperty
    a_pin_reset: assert property (p_pin_reset)
        else $error("pin reset did not reach core");
    property p_hold;
        $fell(o_core_reset) |-> hold_cnt >= 16'(RESET_HOLD_CYC);
    endproperty
    a_hold: assert property (p_hold)
        else $error("reset released too early");
    property p_reset_quiet;
        o_core_reset && $past(o_core_reset) |-> o_pins == '0 && !o_asleep && !o_wake_event;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs active during reset");
    property p_reset_int;
        o_core_reset && $past(o_core_reset) |-> o_int_pin;
    endproperty
    a_reset_int: assert property (p_reset_int)
        else $error("interrupt active during reset");
    property p_wake_gate;
        !wake_en |-> !o_wake_event;
    endproperty
    a_wake_gate: assert property (p_wake_gate)
        else $error("wake seen while disabled");
    property p_wake_pulse;
        o_wake_event |=> !o_wake_event;
    endproperty
    a_wake_pulse: assert property (p_wake_pulse)
        else $error("wake event longer than one cycle");
    property p_wr_answer;
        wr_go |-> ##2 s_axi_bvalid;
    endproperty
    a_wr_answer: assert property (p_wr_answer)
        else $error("write response late");
    property p_rd_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read response late");

    // Main scenarios reached
    c_wake: cover property (o_wake_event);
    c_int: cover property (!o_int_pin && !o_core_reset);
    c_release: cover property ($fell(o_core_reset));
endmodule

bind tpc_pin_control tpc_pin_control_props #(.RESET_HOLD_CYC(RESET_HOLD_CYC)) u_props (.*);
`default_nettype wire

// >>> tpc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module tpc_host_model
(
    input  wire logic  i_mclk,
    input  wire logic  i_clr,
    input  wire logic  i_rst_req,
    input  wire logic  i_wake_req,
    input  wire logic  i_int_pin,
    output logic       o_reset_n,
    output logic       o_wake,
    output logic [7:0] o_int_seen
);
    logic int_q;

    // Reset line low only while a reset is wanted
    assign o_reset_n = !i_rst_req;
    // Wake line raised to pull the device out of sleep
    assign o_wake = i_wake_req;

    // Falling edges counted, as a falling-edge host input
    always_ff @(posedge i_mclk)
    begin
        int_q <= i_int_pin;
        if (i_clr)
            o_int_seen <= 8'h00;
        else if (int_q && !i_int_pin)
            o_int_seen <= o_int_seen + 8'h01;
    end
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ns
`include "tpc_defs.svh"
`default_nettype none
module tb_top
    import tpc_pkg::*;
;
    localparam int HOLD = 20;
    localparam logic [31:0] A_DATA = {18'h0, `TPC_IDX_PIN_DATA, 2'b00};
    localparam logic [31:0] A_DIR = {18'h0, `TPC_IDX_PIN_DIRECTION, 2'b00};
    localparam logic [31:0] A_CFG = {18'h0, `TPC_IDX_SLEEP_CFG0, 2'b00};
    localparam logic [31:0] A_STAT = {18'h0, `TPC_IDX_INT_STATUS, 2'b00};
    localparam logic [31:0] A_MASK = {18'h0, `TPC_IDX_INT_MASK, 2'b00};
    localparam logic [31:0] A_EN = {18'h0, `TPC_IDX_INT_ENABLE, 2'b00};
    localparam logic [31:0] A_CTL = {18'h0, `TPC_IDX_CONTROL, 2'b00};
    localparam logic [31:0] A_PER = {18'h0, `TPC_IDX_SLEEP_PERIOD, 2'b00};
    localparam logic [31:0] A_RF = {18'h0, `TPC_IDX_RF_OVERRIDE, 2'b00};

    logic        i_mclk, i_srst, i_reset_n_pin, i_wake_pin, i_slow_tick_xtal, i_slow_tick_int;
    logic [5:0]  i_pin_in, dir;
    logic [2:0]  i_rf_ctrl;
    tpc_pins_s   o_pins;
    logic        o_int_pin, o_wake_event, o_asleep, o_core_reset, rst_req, wake_req;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]  int_seen;
    int          error_cnt, cmp_count, cyc, n;

    tpc_pin_control #(.RESET_HOLD_CYC(HOLD)) u_tpc_pin_control (.*);
    tpc_host_model u_tpc_host_model (.i_mclk, .i_clr(i_srst), .i_rst_req(rst_req),
        .i_wake_req(wake_req), .i_int_pin(o_int_pin), .o_reset_n(i_reset_n_pin),
        .o_wake(i_wake_pin), .o_int_seen(int_seen));

    // ****
    // Clock, timeout and report
    // ****
    initial
    begin
        i_mclk = 1'b0;
        forever #10 i_mclk = ~i_mclk;
    end

    // Hang guard
    always @(posedge i_mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // ****
    // Bus and pin tasks
    // ****
    task automatic cyc_n(input int k);
        repeat (k) @(posedge i_mclk);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge i_mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever
        begin
            @(posedge i_mclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
                break;
        end
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(er));
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge i_mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever
        begin
            @(posedge i_mclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
                break;
        end
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, exp);
        chk(32'(s_axi_rresp), 32'(er));
    endtask

    task automatic wake_pulse(output int k);
        k = 0;
        wake_req <= 1'b1;
        repeat (8)
        begin
            @(posedge i_mclk);
            if (o_wake_event === 1'b1)
                k++;
        end
        wake_req <= 1'b0;
        cyc_n(4);
    endtask

    task automatic tick(input logic sel, input int k);
        repeat (k)
        begin
            if (sel)
                i_slow_tick_int <= 1'b1;
            else
                i_slow_tick_xtal <= 1'b1;
            cyc_n(3);
            i_slow_tick_int <= 1'b0;
            i_slow_tick_xtal <= 1'b0;
            cyc_n(3);
        end
    endtask

    task automatic wait_rel(output int k);
        k = 0;
        while (o_core_reset !== 1'b0 && k < 200)
        begin
            @(posedge i_mclk);
            k++;
        end
    endtask

    // ****
    // Test sequence
    // ****
    initial
    begin
        {i_srst, s_axi_wstrb} = 5'h1f;
        {rst_req, wake_req, i_pin_in, i_rf_ctrl, i_slow_tick_xtal, i_slow_tick_int} = '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        cyc_n(4);
        i_srst <= 1'b0;
        wait_rel(n);
        chk(32'(o_pins), 32'h0);
        chk(32'(o_int_pin), 32'h1);
        rd(A_DIR, 32'h0, 2'b00);
        rd(A_CFG, 32'h0, 2'b00);
        rd(A_MASK, 32'h7, 2'b00);
        rd(A_EN, 32'h0, 2'b00);
        rd(A_CTL, 32'h0, 2'b00);
        rd(32'h0000_0100, 32'h0, 2'b10);
        wr(32'h0000_0100, 32'h1, 2'b10);
        s_axi_wstrb <= 4'h0;
        wr(A_DIR, 32'h3f, 2'b00);
        s_axi_wstrb <= 4'hf;
        rd(A_DIR, 32'h0, 2'b00);
        $display("test reset_values done");
        for (int k = 0; k < 3; k++)
        begin
            dir = (k == 0) ? 6'h2a : (k == 1) ? 6'h15 : 6'h3f;
            wr(A_DIR, 32'(dir), 2'b00);
            wr(A_DATA, 32'(dir ^ 6'h0f), 2'b00);
            cyc_n(2);
            chk(32'(o_pins.oe), 32'(dir));
            chk(32'(o_pins.out & o_pins.oe), 32'((dir ^ 6'h0f) & dir));
            i_pin_in <= dir ^ 6'h33;
            cyc_n(4);
            rd(A_DATA, 32'(dir ^ 6'h33), 2'b00);
        end
        wr(A_DIR, 32'h0, 2'b00);
        wr(A_RF, 32'h7, 2'b00);
        for (int k = 0; k < 8; k++)
        begin
            i_rf_ctrl <= 3'(k);
            cyc_n(3);
            chk(32'({o_pins.oe, o_pins.out[2:0]}), 32'({6'h07, 3'(k)}));
        end
        wr(A_RF, 32'h0, 2'b00);
        cyc_n(2);
        chk(32'(o_pins.oe), 32'h0);
        $display("test pins done");
        wr(A_STAT, 32'h7, 2'b00);
        wake_pulse(n);
        chk(32'(n), 32'h0);
        rd(A_STAT, 32'h0, 2'b00);
        wr(A_CTL, 32'h1, 2'b00);
        wake_pulse(n);
        chk(32'(n), 32'h1);
        rd(A_STAT, 32'h1, 2'b00);
        wr(A_EN, 32'h1, 2'b00);
        cyc_n(2);
        chk(32'(o_int_pin), 32'h1);
        wr(A_EN, 32'h0, 2'b00);
        wr(A_MASK, 32'h6, 2'b00);
        cyc_n(2);
        chk(32'(o_int_pin), 32'h1);
        wr(A_EN, 32'h1, 2'b00);
        cyc_n(2);
        chk(32'({o_int_pin, int_seen}), 32'h001);
        wr(A_CFG, 32'h2, 2'b00);
        cyc_n(2);
        chk(32'(o_int_pin), 32'h1);
        wr(A_STAT, 32'h1, 2'b00);
        cyc_n(2);
        chk(32'(o_int_pin), 32'h0);
        rd(A_STAT, 32'h0, 2'b00);
        wr(A_CFG, 32'h0, 2'b00);
        $display("test wake_interrupt done");
        wr(A_PER, 32'h4, 2'b00);
        for (int s = 0; s < 2; s++)
        begin
            wr(A_CFG, 32'(s), 2'b00);
            wr(A_STAT, 32'h7, 2'b00);
            wr(A_CTL, {29'h0, 1'(s), 2'b10}, 2'b00);
            n = 0;
            while (o_asleep !== 1'b1 && n < 12)
            begin
                tick(1'(s), 1);
                n++;
            end
            chk(32'(o_asleep), 32'h1);
            tick(1'(1 - s), 10);
            chk(32'(o_asleep), 32'h1);
            wr(A_CTL, {29'h0, 1'(s), 2'b00}, 2'b00);
            n = 0;
            while (o_asleep === 1'b1 && n < 12)
            begin
                tick(1'(s), 1);
                n++;
            end
            chk(32'(n > 2 && n < 6), 32'h1);
            rd(A_STAT, 32'h2, 2'b00);
            wr(A_CTL, 32'h0, 2'b00);
        end
        $display("test sleep done");
        wr(A_DIR, 32'h3f, 2'b00);
        rst_req <= 1'b1;
        cyc_n(5);
        chk(32'(o_core_reset), 32'h1);
        rst_req <= 1'b0;
        wait_rel(n);
        chk(32'(n >= HOLD && n <= HOLD + 5), 32'h1);
        rd(A_DIR, 32'h0, 2'b00);
        $display("test pin_reset done");
        stop_test();
    end
endmodule
`default_nettype wire
